//--- hdl/mpurs_map.vh
`ifndef MPURS_MAP_VH
`define MPURS_MAP_VH
// register byte addresses on the private peripheral bus
`define MPURS_ADDR_RNR 32'hE000ED98
`define MPURS_ADDR_RBAR 32'hE000ED9C
`define MPURS_ADDR_RASR 32'hE000EDA0
`define MPURS_ADDR_RBAR_A1 32'hE000EDA4
`define MPURS_ADDR_RASR_A1 32'hE000EDA8
`define MPURS_ADDR_RBAR_A2 32'hE000EDAC
`define MPURS_ADDR_RASR_A2 32'hE000EDB0
`define MPURS_ADDR_RBAR_A3 32'hE000EDB4
`define MPURS_ADDR_RASR_A3 32'hE000EDB8
// status register, block's own placement
`define MPURS_ADDR_MMSR 32'hE000EDBC
// region count and field layout
`define MPURS_NREG 8
`define MPURS_RNUM_W 4
`define MPURS_RBAR_VALID 4
`define MPURS_RASR_MASK 32'h173FFF3F
`define MPURS_RASR_EN 0
`define MPURS_SIZE_LSB 1
`define MPURS_SIZE_MSB 5
`define MPURS_SUBDIS_LSB 8
`define MPURS_SUBDIS_MSB 15
`define MPURS_AP_LSB 24
`define MPURS_AP_MSB 26
`define MPURS_XN 28
`define MPURS_SIZE_MIN 5'h04
`define MPURS_SIZE_SUB 5'h07
// access permission encodings
`define MPURS_AP_NONE 3'h0
`define MPURS_AP_PRIV 3'h1
`define MPURS_AP_URO 3'h2
`define MPURS_AP_FULL 3'h3
`define MPURS_AP_PRO 3'h5
`define MPURS_AP_RO 3'h6
`define MPURS_AP_RO2 3'h7
// status bits
`define MPURS_ST_IACC 0
`define MPURS_ST_DACC 1
`define MPURS_ST_VALID 7
`endif

//--- hdl/mpurs_region_match.v
`include "mpurs_map.vh"

// one region: base compare by size, subregion decode
module mpurs_region_match (
    input wire [31:0] addr_i,
    input wire [31:0] base_i,
    input wire [31:0] attr_i,
    output wire hit_o
);
    wire [4:0] size_w;
    wire [5:0] n_w;
    wire [31:0] mask_w;
    wire [2:0] sub_w;
    wire [7:0] subdis_w;
    wire [31:0] shifted_w;
    wire in_w;
    wire sub_off_w;

    assign size_w = attr_i[`MPURS_SIZE_MSB:`MPURS_SIZE_LSB];
    // bytes = 2^(size+1); n is the log2 of the span
    assign n_w = {1'b0, size_w} + 6'h01;
    assign mask_w = (n_w >= 6'h20) ? 32'h00000000 : (32'hFFFFFFFF << n_w);
    assign in_w = ((addr_i & mask_w) == (base_i & mask_w));
    // subregion index is the top three address bits inside the region
    assign shifted_w = addr_i >> (n_w - 6'h03);
    assign sub_w = (n_w >= 6'h20) ? addr_i[31:29] : shifted_w[2:0];
    assign subdis_w = attr_i[`MPURS_SUBDIS_MSB:`MPURS_SUBDIS_LSB];
    // small regions ignore the field; bit 0 is the lowest subregion
    assign sub_off_w = (size_w >= `MPURS_SIZE_SUB) & subdis_w[sub_w];
    assign hit_o = attr_i[`MPURS_RASR_EN] & (size_w >= `MPURS_SIZE_MIN) & in_w & ~sub_off_w;
endmodule // mpurs_region_match

//--- hdl/mpurs_top.v
// How it works
// - a permission violation raises a memory fault and records its cause in status
// - number, base and attribute registers are each writable, or by one multi-word store
// - alias pairs of base and attribute registers let one store program four regions
// - number register at E000ED98, base at plus four, attribute at plus eight
// - base write with bit 4 set loads base and region number together
// - register writes take effect in order, one per cycle, no reordering
// - regions of 256 bytes or more split into eight equal subregions
// - subregion bit zero is lowest addressed, highest bit the top subregion
// - disabled subregion falls through to other regions, else background or fault
// - registers take aligned words only; other widths are ignored
// - region size is two to the size field plus one, minimum field four
// - valid bit set copies region field to number register, clear ignores it
`include "mpurs_map.vh"

module mpurs_top (
    input wire clk_i,
    input wire nrst_i,
    // register port from the private peripheral bus
    input wire reg_sel_i,
    input wire reg_wr_i,
    input wire [31:0] reg_addr_i,
    input wire [1:0] reg_size_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    output reg reg_ready_o,
    // access check from the load/store pipeline
    input wire chk_valid_i,
    input wire [31:0] chk_addr_i,
    input wire chk_write_i,
    input wire chk_fetch_i,
    input wire chk_priv_i,
    input wire mpu_enable_i,
    input wire bg_enable_i,
    output reg chk_done_o,
    output reg memory_manage_fault_o,
    output reg [31:0] fault_addr_o
);
    localparam NR = `MPURS_NREG;

    reg [31:0] base_r [0:NR-1];
    reg [31:0] attr_r [0:NR-1];
    reg [3:0] region_number_select_r;
    reg [7:0] memfault_status_r;

    wire [NR-1:0] hit_w;
    wire [NR*3-1:0] ap_w;
    wire [NR-1:0] xn_w;

    // one matcher per region
    genvar g;
    generate
        for (g = 0; g < NR; g = g + 1) begin : g_reg
            mpurs_region_match u_match (
                .addr_i(chk_addr_i),
                .base_i(base_r[g]),
                .attr_i(attr_r[g]),
                .hit_o(hit_w[g])
            );
            assign ap_w[g*3+2:g*3] = attr_r[g][`MPURS_AP_MSB:`MPURS_AP_LSB];
            assign xn_w[g] = attr_r[g][`MPURS_XN];
        end
    endgenerate

    // highest numbered matching region wins; disabled subregions drop out
    reg found_w;
    reg [2:0] ap_sel_w;
    reg xn_sel_w;
    integer i;
    always @* begin
        found_w = 1'b0;
        ap_sel_w = `MPURS_AP_NONE;
        xn_sel_w = 1'b0;
        for (i = 0; i < NR; i = i + 1) begin
            if (hit_w[i]) begin
                found_w = 1'b1;
                ap_sel_w = ap_w[i*3 +: 3];
                xn_sel_w = xn_w[i];
            end
        end
    end

    // permission table: one row per encoding, split by privilege and direction
    reg priv_rd_w;
    reg priv_wr_w;
    reg user_rd_w;
    reg user_wr_w;
    always @* begin
        priv_rd_w = 1'b0;
        priv_wr_w = 1'b0;
        user_rd_w = 1'b0;
        user_wr_w = 1'b0;
        case (ap_sel_w)
            `MPURS_AP_PRIV: begin
                priv_rd_w = 1'b1;
                priv_wr_w = 1'b1;
            end
            `MPURS_AP_URO: begin
                priv_rd_w = 1'b1;
                priv_wr_w = 1'b1;
                user_rd_w = 1'b1;
            end
            `MPURS_AP_FULL: begin
                priv_rd_w = 1'b1;
                priv_wr_w = 1'b1;
                user_rd_w = 1'b1;
                user_wr_w = 1'b1;
            end
            `MPURS_AP_PRO: begin
                priv_rd_w = 1'b1;
            end
            `MPURS_AP_RO, `MPURS_AP_RO2: begin
                priv_rd_w = 1'b1;
                user_rd_w = 1'b1;
            end
            // no access and the reserved code both refuse, safest for a bad setup
            default: begin
                priv_rd_w = 1'b0;
            end
        endcase
    end

    // pick the column for this access; execute-never blocks every fetch
    reg allow_w;
    always @* begin
        if (chk_priv_i) begin
            allow_w = chk_write_i ? priv_wr_w : priv_rd_w;
        end else begin
            allow_w = chk_write_i ? user_wr_w : user_rd_w;
        end
        if (chk_fetch_i & xn_sel_w) begin
            allow_w = 1'b0;
        end
    end

    // background map covers privileged code only, and only when switched on
    wire bg_ok_w;
    assign bg_ok_w = chk_priv_i & bg_enable_i;
    // protection off never refuses; a miss falls back to the background map
    wire bad_w;
    assign bad_w = mpu_enable_i & (found_w ? ~allow_w : ~bg_ok_w);

    // register decode: word accesses only, others ignored
    wire word_w;
    wire wr_w;
    assign word_w = (reg_size_i == 2'h2) & (reg_addr_i[1:0] == 2'h0);
    assign wr_w = reg_sel_i & reg_wr_i & word_w;

    // fixed registers; the number register anchors the base and attribute pair
    wire is_rnr_w;
    wire is_mmsr_w;
    assign is_rnr_w = (reg_addr_i == `MPURS_ADDR_RNR);
    assign is_mmsr_w = (reg_addr_i == `MPURS_ADDR_MMSR);

    // alias pair index: 0 main, 1..3 aliases
    reg is_base_w;
    reg is_attr_w;
    always @* begin
        is_base_w = 1'b0;
        is_attr_w = 1'b0;
        case (reg_addr_i)
            `MPURS_ADDR_RBAR, `MPURS_ADDR_RBAR_A1,
            `MPURS_ADDR_RBAR_A2, `MPURS_ADDR_RBAR_A3: is_base_w = 1'b1;
            `MPURS_ADDR_RASR, `MPURS_ADDR_RASR_A1,
            `MPURS_ADDR_RASR_A2, `MPURS_ADDR_RASR_A3: is_attr_w = 1'b1;
            default: is_base_w = 1'b0;
        endcase
    end

    // base write with valid updates the number and the base of that region in the same cycle
    wire valid_w;
    wire [3:0] tgt_w;
    assign valid_w = is_base_w & reg_wdata_i[`MPURS_RBAR_VALID];
    assign tgt_w = valid_w ? reg_wdata_i[3:0] : region_number_select_r;

    // write strobes per register kind; numbers past the table select nothing
    wire rnr_we_w;
    wire base_we_w;
    wire attr_we_w;
    assign rnr_we_w = wr_w & is_rnr_w;
    assign base_we_w = wr_w & is_base_w & (tgt_w < NR);
    assign attr_we_w = wr_w & is_attr_w & (region_number_select_r < NR);

    // next region number: a direct write or a valid base write
    reg [3:0] region_number_select_nxt;
    always @* begin
        region_number_select_nxt = region_number_select_r;
        if (rnr_we_w) begin
            region_number_select_nxt = reg_wdata_i[3:0];
        end
        if (wr_w & valid_w) begin
            region_number_select_nxt = reg_wdata_i[3:0];
        end
    end

    // number register and region tables; one write per cycle keeps order
    integer k;
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            region_number_select_r <= 4'h0;
            for (k = 0; k < NR; k = k + 1) begin
                base_r[k] <= 32'h00000000;
                attr_r[k] <= 32'h00000000;
            end
        end else begin
            region_number_select_r <= region_number_select_nxt;
            if (base_we_w) begin
                base_r[tgt_w[2:0]] <= {reg_wdata_i[31:5], 5'h00};
            end
            if (attr_we_w) begin
                attr_r[region_number_select_r[2:0]] <=
                    reg_wdata_i & `MPURS_RASR_MASK;
            end
        end
    end

    // read data; unmapped or narrow reads return zero
    reg [31:0] rd_w;
    wire cur_ok_w;
    assign cur_ok_w = region_number_select_r < NR;
    always @* begin
        rd_w = 32'h00000000;
        if (word_w) begin
            if (is_rnr_w) begin
                rd_w = {28'h0000000, region_number_select_r};
            end else if (is_base_w) begin
                // valid reads as zero, region field shows current number
                rd_w = {cur_ok_w ? base_r[region_number_select_r[2:0]][31:5] : 27'h0,
                    1'b0, region_number_select_r};
            end else if (is_attr_w) begin
                rd_w = cur_ok_w ? attr_r[region_number_select_r[2:0]] : 32'h00000000;
            end else if (is_mmsr_w) begin
                rd_w = {24'h000000, memfault_status_r};
            end
        end
    end

    // read data gated to reads so writes and idle cycles show zero
    reg [31:0] reg_rdata_nxt;
    always @* begin
        reg_rdata_nxt = 32'h00000000;
        if (reg_sel_i & ~reg_wr_i) begin
            reg_rdata_nxt = rd_w;
        end
    end

    // bus answer one cycle after select; no wait states, so writes stay in order
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h00000000;
            reg_ready_o <= 1'b0;
        end else begin
            reg_ready_o <= reg_sel_i;
            reg_rdata_o <= reg_rdata_nxt;
        end
    end

    // fault kinds: a fetch fault has no meaningful data address
    wire clr_w;
    assign clr_w = wr_w & is_mmsr_w;
    wire flt_w;
    assign flt_w = chk_valid_i & bad_w;
    wire dflt_w;
    wire iflt_w;
    assign dflt_w = flt_w & ~chk_fetch_i;
    assign iflt_w = flt_w & chk_fetch_i;

    // status write-one-to-clear; a new fault in the same cycle wins
    reg [7:0] memfault_clr_w;
    reg [7:0] memfault_set_w;
    reg [7:0] memfault_status_nxt;
    always @* begin
        memfault_clr_w = clr_w ? reg_wdata_i[7:0] : 8'h00;
        memfault_set_w = 8'h00;
        memfault_set_w[`MPURS_ST_IACC] = iflt_w;
        memfault_set_w[`MPURS_ST_DACC] = dflt_w;
        memfault_set_w[`MPURS_ST_VALID] = dflt_w;
        memfault_status_nxt = (memfault_status_r & ~memfault_clr_w) | memfault_set_w;
    end

    // fault address follows data faults only; fetch faults leave it alone
    reg [31:0] fault_addr_nxt;
    always @* begin
        fault_addr_nxt = fault_addr_o;
        if (dflt_w) begin
            fault_addr_nxt = chk_addr_i;
        end
    end

    // check answer and status, all registered
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            memfault_status_r <= 8'h00;
            memory_manage_fault_o <= 1'b0;
            chk_done_o <= 1'b0;
            fault_addr_o <= 32'h00000000;
        end else begin
            memfault_status_r <= memfault_status_nxt;
            memory_manage_fault_o <= flt_w;
            chk_done_o <= chk_valid_i;
            fault_addr_o <= fault_addr_nxt;
        end
    end
endmodule // mpurs_top

//--- tb/mpurs_sva.sv
module mpurs_sva (
    input wire clk_i,
    input wire nrst_i,
    input wire reg_sel_i,
    input wire reg_wr_i,
    input wire [1:0] reg_size_i,
    input wire [31:0] reg_rdata_o,
    input wire reg_ready_o,
    input wire chk_valid_i,
    input wire [31:0] chk_addr_i,
    input wire chk_fetch_i,
    input wire mpu_enable_i,
    input wire chk_done_o,
    input wire memory_manage_fault_o,
    input wire [31:0] fault_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // data access refused one cycle after it was taken
    sequence s_dfault;
        chk_valid_i && !chk_fetch_i ##1 memory_manage_fault_o;
    endsequence
    a_ready_after_sel: assert property (reg_sel_i |=> reg_ready_o)
        else $error("ready missing");
    a_ready_no_req: assert property (!reg_sel_i |=> !reg_ready_o)
        else $error("stray ready");
    a_rdata_idle_zero: assert property (!reg_ready_o |-> reg_rdata_o == 32'h0)
        else $error("read data outside ready");
    a_narrow_read_zero: assert property (
        reg_sel_i && !reg_wr_i && reg_size_i != 2'h2 |=> reg_rdata_o == 32'h0)
        else $error("narrow read not zero");
    a_done_after_chk: assert property (chk_valid_i |=> chk_done_o)
        else $error("check not answered");
    a_fault_with_done: assert property (memory_manage_fault_o |-> chk_done_o)
        else $error("fault without done");
    a_off_no_fault: assert property (chk_valid_i && !mpu_enable_i |=> !memory_manage_fault_o)
        else $error("fault while off");
    a_fault_addr_kept: assert property (s_dfault |-> fault_addr_o == $past(chk_addr_i))
        else $error("fault address wrong");
endmodule // mpurs_sva

bind mpurs_top mpurs_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_size_i(reg_size_i), .reg_rdata_o(reg_rdata_o),
    .reg_ready_o(reg_ready_o), .chk_valid_i(chk_valid_i), .chk_addr_i(chk_addr_i),
    .chk_fetch_i(chk_fetch_i), .mpu_enable_i(mpu_enable_i), .chk_done_o(chk_done_o),
    .memory_manage_fault_o(memory_manage_fault_o), .fault_addr_o(fault_addr_o));

//--- tb/mpurs_lsu_model.sv
module mpurs_lsu_model (
    input wire clk_i,
    input wire chk_done_i,
    input wire fault_i,
    output logic chk_valid_o = 1'b0,
    output logic [31:0] chk_addr_o = 32'h0,
    output logic chk_write_o = 1'b0,
    output logic chk_fetch_o = 1'b0,
    output logic chk_priv_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one access at a time, nothing left buffered across a reconfiguration
    task automatic access(input [31:0] a, input w, input p, output f, output k,
        input e = 1'b0);
        chk_valid_o = 1'b1;
        chk_addr_o = a;
        chk_write_o = w;
        chk_fetch_o = e;
        chk_priv_o = p;
        @(posedge clk_i);
        @(negedge clk_i);
        k = chk_done_i;
        f = fault_i;
        chk_valid_o = 1'b0;
        chk_addr_o = ~a; // released bus must not show a stale address
        chk_fetch_o = 1'b0;
        @(negedge clk_i); // idle cycle: the next call never re-raises valid here
    endtask
endmodule // mpurs_lsu_model

//--- tb/mpurs_tb_top.sv
`include "mpurs_map.vh"
module mpurs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic men = 1'b1;
    logic bg = 1'b0;
    logic [1:0] sz = 2'h2;
    logic [31:0] adr = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd, rdv, cad, fad;
    logic rdy, vld, cwr, fet, prv, done, mmf, flt, ok, ef;
    logic [15:0] lf = 16'h7105;
    logic [7:0] sdm;
    logic [9:0] off;
    int fails = 0;
    int check_count = 0;

    initial forever #4 clk_i = ~clk_i;

    mpurs_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_sel_i(sel), .reg_wr_i(wr),
        .reg_addr_i(adr), .reg_size_i(sz), .reg_wdata_i(wd), .reg_rdata_o(rd),
        .reg_ready_o(rdy), .chk_valid_i(vld), .chk_addr_i(cad), .chk_write_i(cwr),
        .chk_fetch_i(fet), .chk_priv_i(prv), .mpu_enable_i(men), .bg_enable_i(bg),
        .chk_done_o(done), .memory_manage_fault_o(mmf), .fault_addr_o(fad));
    mpurs_lsu_model u_lsu (.clk_i(clk_i), .chk_done_i(done), .fault_i(mmf),
        .chk_valid_o(vld), .chk_addr_o(cad), .chk_write_o(cwr), .chk_fetch_o(fet),
        .chk_priv_o(prv));

    function automatic logic [15:0] nx(input [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // refused only in a disabled subregion without background cover
    function automatic logic exp_sub(input [9:0] o, input [7:0] m, input p);
        return m[o[9:7]] && !(p && bg);
    endfunction
    task automatic cmp(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // strobe held high between calls, lowered by the caller
    task automatic rg(input w, input [31:0] a, input [31:0] d, input [1:0] s = 2'h2);
        sel = 1'b1;
        wr = w;
        adr = a;
        wd = d;
        sz = s;
        @(posedge clk_i);
        @(negedge clk_i);
        cmp({31'h0, rdy}, 32'h1);
        rdv = rd;
    endtask
    task automatic ck(input [31:0] a, input p, input e);
        u_lsu.access(a, lf[14], p, flt, ok);
        cmp({30'h0, ok, flt}, {30'h0, 1'b1, e});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        // narrow accesses change and return nothing
        rg(1'b1, `MPURS_ADDR_RNR, 32'h3, 2'h1);
        rg(1'b0, `MPURS_ADDR_RNR, 32'h0, 2'h1);
        cmp(rdv, 32'h0);
        rg(1'b0, `MPURS_ADDR_RNR, 32'h0);
        cmp(rdv, 32'h0);
        // separate words, enable set only after base and attributes
        rg(1'b1, `MPURS_ADDR_RNR, 32'h2);
        rg(1'b1, `MPURS_ADDR_RASR, 32'h03000012);
        rg(1'b1, `MPURS_ADDR_RBAR, 32'h20001000);
        rg(1'b1, `MPURS_ADDR_RASR, 32'h03000013);
        rg(1'b0, `MPURS_ADDR_RBAR, 32'h0);
        cmp(rdv, 32'h20001002);
        // alias pairs: 32 byte no-access region 6, region 1 left off
        rg(1'b1, `MPURS_ADDR_RBAR_A1, 32'h30000016);
        rg(1'b1, `MPURS_ADDR_RASR_A1, 32'h00000009);
        rg(1'b1, `MPURS_ADDR_RBAR_A2, 32'h20000011);
        rg(1'b1, `MPURS_ADDR_RASR_A2, 32'h0300001E);
        rg(1'b0, `MPURS_ADDR_RNR, 32'h0);
        cmp(rdv, 32'h1);
        sel = 1'b0;
        bg = 1'b1;
        ck(32'h3000001C, 1'b1, 1'b1);
        cmp(fad, 32'h3000001C);
        ck(32'h30000020, 1'b1, 1'b0);
        rg(1'b0, `MPURS_ADDR_MMSR, 32'h0);
        cmp(rdv, 32'h00000082);
        rg(1'b1, `MPURS_ADDR_MMSR, 32'hFF);
        rg(1'b0, 32'hE000EDC0, 32'h0);
        cmp(rdv, 32'h0);
        // random masks, offsets and privilege; first two hit the subregion edge
        for (int i = 0; i < 24; i++) begin
            lf = nx(lf);
            sdm = (i < 2) ? 8'h01 : lf[7:0];
            bg = lf[8];
            rg(1'b1, `MPURS_ADDR_RNR, 32'h2);
            rg(1'b1, `MPURS_ADDR_RASR, {16'h0300, sdm, 8'h13});
            sel = 1'b0;
            lf = nx(lf);
            off = (i < 2) ? 10'h07C + 10'(i * 4) : lf[9:0];
            ef = exp_sub(off, sdm, lf[15]);
            ck(32'h20001000 + {22'h0, off[9:2], 2'h0}, lf[15], ef);
        end
        // disabled subregion falls through to enabled region 1
        rg(1'b1, `MPURS_ADDR_RASR, 32'h0300FF13);
        rg(1'b1, `MPURS_ADDR_RNR, 32'h1);
        rg(1'b1, `MPURS_ADDR_RASR, 32'h0300001F);
        sel = 1'b0;
        bg = 1'b0;
        ck(32'h20001040, 1'b0, 1'b0);
        // execute-never on region 1: fetch fault sets only the fetch bit
        rg(1'b1, `MPURS_ADDR_RASR, 32'h1300001F);
        rg(1'b1, `MPURS_ADDR_MMSR, 32'hFF);
        sel = 1'b0;
        u_lsu.access(32'h20001040, 1'b0, 1'b1, flt, ok, 1'b1);
        cmp({30'h0, ok, flt}, 32'h3);
        rg(1'b0, `MPURS_ADDR_MMSR, 32'h0);
        cmp(rdv, 32'h00000001);
        sel = 1'b0;
        men = 1'b0;
        ck(32'h30000000, 1'b1, 1'b0);
        give_verdict();
    end
endmodule // mpurs_tb_top
